/* File: rtl/six_step_consts.vh */
`ifndef SIX_STEP_CONSTS_VH
`define SIX_STEP_CONSTS_VH
// register word indexes
`define R_CTRL      4'h0
`define R_STATUS    4'h1
`define R_INIT_PER  4'h2
`define R_ACCEL     4'h3
`define R_OL_COUNT  4'h4
`define R_DECAY     4'h5
`define R_DUTY_THR  4'h6
`define R_DUTY      4'h7
`define R_ALIGN_T   4'h8
`define R_ALIGN_DTY 4'h9
`define R_ADVANCE   4'ha
`define R_FREEWHEEL 4'hb
`define R_OFFSET    4'hc
`define R_IBUS_FILT 4'hd
`define R_VBUS_FILT 4'he
// control and status fields
`define CTRL_RUN_BIT   0
`define CTRL_CLR_BIT   1
`define ST_STATE_LSB   0
`define ST_FAULT_LSB   4
`define ST_POST_BIT    8
`define ST_FOUND_BIT   9
`define ST_SECTOR_LSB  12
// reset values
`define RST_INIT_PER  16'h4000
`define RST_ACCEL     16'he000
`define RST_OL_COUNT  8'h10
`define RST_DECAY     16'h0100
`define RST_DUTY_THR  16'h0800
`define RST_DUTY      16'h2000
`define RST_ALIGN_T   16'h0064
`define RST_ALIGN_DTY 16'h1000
`define RST_ADVANCE   16'h61a9
`define RST_FREEWHEEL 16'h00c8
// application states
`define S_INIT  3'h0
`define S_CALIB 3'h1
`define S_ALIGN 3'h2
`define S_START 3'h3
`define S_RUN   3'h4
`define S_STOP  3'h5
`define S_FAULT 3'h6
// timing
`define TICK_MS 1
`define CLK_KHZ 40000
`endif

/* File: rtl/six_step_commutation.v */
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "six_step_consts.vh"
module six_step_commutation #(
  parameter TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // avalon-mm slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // converter samples
  input  wire        conv_done,
  input  wire [11:0] phase_sample,
  input  wire [11:0] bus_i_sample,
  input  wire [11:0] bus_v_sample,
  // fault sources
  input  wire        under_voltage,
  input  wire        over_voltage,
  input  wire        over_current,
  input  wire        driver_fault,
  // power stage
  output wire [2:0]  phase_high_en,
  output wire [2:0]  phase_low_en,
  output wire [15:0] pwm_duty,
  output wire [1:0]  back_emf_channel,
  output wire        commutation_pulse,
  output wire        speed_loop_tick
);
  localparam [31:0] TICK_SPAN = TICK_CYCLES - 1;
  localparam [15:0] TICK_LAST = TICK_SPAN[15:0];

  // gate pattern {high, low} per sector
  function [5:0] gate_of;
    input [2:0] s;
    begin
      case (s)
        3'h0: gate_of = 6'b001_010;
        3'h1: gate_of = 6'b001_100;
        3'h2: gate_of = 6'b010_100;
        3'h3: gate_of = 6'b010_001;
        3'h4: gate_of = 6'b100_001;
        3'h5: gate_of = 6'b100_010;
        default: gate_of = 6'b000_000;
      endcase
    end
  endfunction

  // floating phase channel per sector: 0=a 1=b 2=c
  function [1:0] float_of;
    input [2:0] s;
    begin
      case (s)
        3'h0, 3'h3: float_of = 2'h2;
        3'h1, 3'h4: float_of = 2'h1;
        default: float_of = 2'h0;
      endcase
    end
  endfunction

  reg [2:0]         state_q;
  reg [3:0]         fault_q;
  reg               run_q;
  reg [15:0]        init_per_q;
  reg [15:0]        accel_q;
  reg [7:0]         ol_n_q;
  reg [15:0]        decay_q;
  reg [15:0]        thr_q;
  reg [15:0]        duty_q;
  reg [15:0]        align_t_q;
  reg [15:0]        align_dty_q;
  reg [15:0]        adv_q;
  reg [15:0]        fw_q;
  reg [11:0]        offset_q;
  reg               ack_q;
  reg [31:0]        rdata_q;
  reg [15:0]        tick_cnt_q;
  reg               tick_q;
  reg [15:0]        cnt_q;
  reg [15:0]        mod_q;
  reg [15:0]        mod_old_q;
  reg [2:0]         sector_q;
  reg [7:0]         ol_cnt_q;
  reg [15:0]        wait_q;
  reg               post_q;
  reg               found_q;
  reg [15:0]        stamp_q;
  reg [15:0]        stamp_old_q;
  reg [15:0]        zc_q;
  reg [15:0]        avg_q;
  reg signed [12:0] back_emf_old_q;
  reg [11:0]        vh_q [0:3];
  reg [13:0]        vsum_q;
  reg signed [12:0] ih_q [0:3];
  reg signed [14:0] isum_q;
  reg [2:0]         hi_q;
  reg [2:0]         lo_q;
  reg [15:0]        pwm_q;
  reg [1:0]         chan_q;
  reg               comm_q;
  reg [1:0]         chan_out_q;
  integer           k;

  wire [3:0] fault_in = {driver_fault, over_current, over_voltage, under_voltage};
  wire       fault_any = |fault_in;
  wire       req = read | write;
  wire       wr_do = write & ack_q;
  wire       clr_req = wr_do & (address == `R_CTRL) & writedata[`CTRL_CLR_BIT];
  wire       tick = (tick_cnt_q == TICK_LAST);
  wire       driving = (state_q == `S_START) | (state_q == `S_RUN);
  // commutation event at timer overflow
  wire       comm = driving & (cnt_q >= mod_q);
  wire [5:0] gate_now = gate_of(sector_q);

  // bias removal and low-duty current blanking
  wire signed [12:0] i_raw = $signed({1'b0, bus_i_sample}) - $signed({1'b0, offset_q});
  wire signed [12:0] i_in = (duty_q > thr_q) ? i_raw : 13'sh0000;
  wire signed [14:0] isum_d = isum_q + {{2{i_in[12]}}, i_in} - {{2{ih_q[3][12]}}, ih_q[3]};
  wire [13:0]        vsum_d = vsum_q + {2'b00, bus_v_sample} - {2'b00, vh_q[3]};
  wire [11:0]        v_filt = vsum_d[13:2];
  wire signed [12:0] back_emf = $signed({1'b0, phase_sample}) - $signed({2'b00, v_filt[11:1]});
  wire signed [12:0] back_emf_corr = sector_q[0] ? back_emf : -back_emf;
  wire        post_next = post_q & ~(cnt_q > decay_q);
  wire        detect = conv_done & ~post_next & ~found_q & (state_q == `S_RUN);
  wire        hit = detect & ~back_emf_corr[12];
  wire [15:0] half_gap = (cnt_q - stamp_q) >> 1;
  wire [15:0] zc_new = cnt_q - half_gap;
  wire [15:0] per_new = mod_old_q - zc_q + zc_new;
  wire [16:0] avg_sum = {1'b0, avg_q} + {1'b0, per_new};
  wire [15:0] avg_new = avg_sum[16:1];
  wire [31:0] adv_prod = avg_new * adv_q;
  wire [31:0] acc_prod = mod_q * accel_q;

  assign waitrequest = req & ~ack_q;
  assign readdata = rdata_q;
  assign phase_high_en = hi_q;
  assign phase_low_en = lo_q;
  assign pwm_duty = pwm_q;
  assign back_emf_channel = chan_out_q;
  assign commutation_pulse = comm_q;
  assign speed_loop_tick = tick_q;

  // register slave, answer one cycle after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      run_q <= 1'b0;
      init_per_q <= `RST_INIT_PER;
      accel_q <= `RST_ACCEL;
      ol_n_q <= `RST_OL_COUNT;
      decay_q <= `RST_DECAY;
      thr_q <= `RST_DUTY_THR;
      duty_q <= `RST_DUTY;
      align_t_q <= `RST_ALIGN_T;
      align_dty_q <= `RST_ALIGN_DTY;
      adv_q <= `RST_ADVANCE;
      fw_q <= `RST_FREEWHEEL;
    end else begin
      ack_q <= req & ~ack_q;
      if (read & ~ack_q) begin
        case (address)
          `R_CTRL:      rdata_q <= {31'h0000_0000, run_q};
          `R_STATUS:    rdata_q <= {17'h0_0000, sector_q, 2'b00, found_q, post_q,
                                    fault_q, 1'b0, state_q};
          `R_INIT_PER:  rdata_q <= {16'h0000, init_per_q};
          `R_ACCEL:     rdata_q <= {16'h0000, accel_q};
          `R_OL_COUNT:  rdata_q <= {24'h00_0000, ol_n_q};
          `R_DECAY:     rdata_q <= {16'h0000, decay_q};
          `R_DUTY_THR:  rdata_q <= {16'h0000, thr_q};
          `R_DUTY:      rdata_q <= {16'h0000, duty_q};
          `R_ALIGN_T:   rdata_q <= {16'h0000, align_t_q};
          `R_ALIGN_DTY: rdata_q <= {16'h0000, align_dty_q};
          `R_ADVANCE:   rdata_q <= {16'h0000, adv_q};
          `R_FREEWHEEL: rdata_q <= {16'h0000, fw_q};
          `R_OFFSET:    rdata_q <= {20'h0_0000, offset_q};
          `R_IBUS_FILT: rdata_q <= {{19{isum_q[14]}}, isum_q[14:2]};
          `R_VBUS_FILT: rdata_q <= {20'h0_0000, vsum_q[13:2]};
          default:      rdata_q <= 32'h0000_0000;
        endcase
      end
      if (wr_do) begin
        case (address)
          `R_CTRL:      run_q <= writedata[`CTRL_RUN_BIT];
          `R_INIT_PER:  init_per_q <= writedata[15:0];
          `R_ACCEL:     accel_q <= writedata[15:0];
          `R_OL_COUNT:  ol_n_q <= writedata[7:0];
          `R_DECAY:     decay_q <= writedata[15:0];
          `R_DUTY_THR:  thr_q <= writedata[15:0];
          `R_DUTY:      duty_q <= writedata[15:0];
          `R_ALIGN_T:   align_t_q <= writedata[15:0];
          `R_ALIGN_DTY: align_dty_q <= writedata[15:0];
          `R_ADVANCE:   adv_q <= writedata[15:0];
          `R_FREEWHEEL: fw_q <= writedata[15:0];
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q <= tick;
    end
  end

  // measurement path on conversion complete
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vsum_q <= 14'h0000;
      isum_q <= 15'sh0000;
      stamp_q <= 16'h0000;
      stamp_old_q <= 16'h0000;
      for (k = 0; k < 4; k = k + 1) begin
        vh_q[k] <= 12'h000;
        ih_q[k] <= 13'sh0000;
      end
    end else if (conv_done) begin
      vsum_q <= vsum_d;
      isum_q <= isum_d;
      vh_q[0] <= bus_v_sample;
      ih_q[0] <= i_in;
      for (k = 1; k < 4; k = k + 1) begin
        vh_q[k] <= vh_q[k-1];
        ih_q[k] <= ih_q[k-1];
      end
      stamp_old_q <= stamp_q;
      stamp_q <= cnt_q;
    end
  end

  // application sequencer, commutation timer and crossing detector
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= `S_INIT;
      fault_q <= 4'h0;
      offset_q <= 12'h000;
      cnt_q <= 16'h0000;
      mod_q <= 16'hffff;
      mod_old_q <= 16'h0000;
      sector_q <= 3'h0;
      ol_cnt_q <= 8'h00;
      wait_q <= 16'h0000;
      post_q <= 1'b0;
      found_q <= 1'b0;
      zc_q <= 16'h0000;
      avg_q <= 16'h0000;
      back_emf_old_q <= 13'sh0000;
      chan_q <= 2'h0;
      comm_q <= 1'b0;
    end else begin
      comm_q <= comm;
      cnt_q <= comm ? 16'h0000 : (driving ? cnt_q + 16'h0001 : 16'h0000);
      // decay expiry clears the post-commutation flag
      if (conv_done)
        post_q <= post_next;
      if (detect) begin
        back_emf_old_q <= back_emf_corr;
      end
      if (hit) begin
        zc_q <= zc_new;
        avg_q <= avg_new;
        mod_q <= zc_new + adv_prod[31:16];
      end
      if (comm) begin
        sector_q <= (sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1;
        chan_q <= float_of((sector_q == 3'h5) ? 3'h0 : sector_q + 3'h1);
        mod_old_q <= mod_q;
        post_q <= 1'b1;
        found_q <= 1'b0;
      end
      // found flag wins over commutation clear
      if (hit)
        found_q <= 1'b1;
      case (state_q)
        `S_INIT: begin
          if (conv_done) begin
            offset_q <= bus_i_sample;
            wait_q <= fw_q;
            state_q <= `S_STOP;
          end
        end
        `S_STOP: begin
          if (tick && wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          if (run_q && wait_q == 16'h0000) begin
            wait_q <= align_t_q;
            state_q <= `S_ALIGN;
          end
        end
        `S_ALIGN: begin
          if (tick && wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0000) begin
            mod_q <= init_per_q;
            sector_q <= 3'h0;
            chan_q <= float_of(3'h0);
            ol_cnt_q <= 8'h00;
            post_q <= 1'b1;
            found_q <= 1'b0;
            state_q <= `S_START;
          end
        end
        `S_START: begin
          if (comm) begin
            mod_q <= acc_prod[31:16];
            ol_cnt_q <= ol_cnt_q + 8'h01;
            if (ol_cnt_q + 8'h01 >= ol_n_q) begin
              avg_q <= mod_q;
              zc_q <= 16'h0000;
              state_q <= `S_RUN;
            end
          end
        end
        `S_RUN: begin
          if (!run_q)
            state_q <= `S_INIT;
        end
        `S_FAULT: begin
          if (!fault_any && clr_req) begin
            fault_q <= 4'h0;
            state_q <= `S_INIT;
          end
        end
        default: state_q <= `S_INIT;
      endcase
      if (fault_any) begin
        fault_q <= fault_q | fault_in;
        state_q <= `S_FAULT;
      end
    end
  end

  // phase output drive
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= 3'b000;
      lo_q <= 3'b000;
      pwm_q <= 16'h0000;
      chan_out_q <= 2'h0;
    end else begin
      // channel lags the sector like the gates do
      chan_out_q <= chan_q;
      case (state_q)
        `S_ALIGN: begin
          hi_q <= 3'b100;
          lo_q <= 3'b011;
          pwm_q <= align_dty_q;
        end
        `S_START, `S_RUN: begin
          hi_q <= gate_now[5:3];
          lo_q <= gate_now[2:0];
          pwm_q <= duty_q;
        end
        default: begin
          hi_q <= 3'b000;
          lo_q <= 3'b000;
          pwm_q <= 16'h0000;
        end
      endcase
    end
  end
endmodule

/* File: test/six_step_props.sv */
`timescale 1ns/1ps
module six_step_props #(
  parameter TICK_CYCLES = 40
) (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  // register bus
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // fault sources
  input wire        under_voltage,
  input wire        over_voltage,
  input wire        over_current,
  input wire        driver_fault,
  // power stage
  input wire [2:0]  phase_high_en,
  input wire [2:0]  phase_low_en,
  input wire [15:0] pwm_duty,
  input wire [1:0]  back_emf_channel,
  input wire        speed_loop_tick
);
  reg  [31:0] gap_q;
  reg         seen_q;
  wire        any_fault = under_voltage | over_voltage | over_current | driver_fault;

  // cycles since the last speed-loop tick
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q  <= 32'h0000_0000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= speed_loop_tick ? 32'h0000_0000 : gap_q + 32'h0000_0001;
      seen_q <= seen_q | speed_loop_tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus wait longer than one cycle");
  a_bus_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised with no request");
  a_unmapped_zero: assert property (read && waitrequest && address == 4'hf
    |=> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_fault_safe: assert property (any_fault |-> ##2 (phase_high_en == 3'b000
    && phase_low_en == 3'b000 && pwm_duty == 16'h0000)) else $error("drive on in fault");
  a_no_overlap: assert property ((phase_high_en & phase_low_en) == 3'b000)
    else $error("high and low side on together");
  a_align_vector: assert property (phase_low_en == 3'b011 |-> phase_high_en == 3'b100)
    else $error("alignment vector wrong");
  a_floating_chan: assert property ($onehot(phase_high_en) && $onehot(phase_low_en)
    |-> !phase_high_en[back_emf_channel] && !phase_low_en[back_emf_channel])
    else $error("sense channel on a driven phase");
  a_tick_period: assert property (speed_loop_tick && seen_q |-> gap_q == TICK_CYCLES - 1)
    else $error("tick spacing wrong");
  a_tick_bound: assert property (seen_q |-> gap_q < TICK_CYCLES)
    else $error("tick missing");
endmodule

bind six_step_commutation six_step_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .under_voltage(under_voltage),
  .over_voltage(over_voltage), .over_current(over_current), .driver_fault(driver_fault),
  .phase_high_en(phase_high_en), .phase_low_en(phase_low_en), .pwm_duty(pwm_duty),
  .back_emf_channel(back_emf_channel), .speed_loop_tick(speed_loop_tick));

/* File: test/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // drive from the block
  input  wire [2:0]  phase_high_en,
  input  wire [2:0]  phase_low_en,
  input  wire        commutation_pulse,
  // levels chosen by the bench
  input  wire [11:0] bus_v_level,
  input  wire [11:0] bus_i_level,
  // converter results
  output reg         conv_done,
  output wire [11:0] phase_sample,
  output wire [11:0] bus_i_sample,
  output wire [11:0] bus_v_sample
);
  reg  [2:0]  div_q;
  reg  [4:0]  ramp_q;
  // rising slope when the low side is the high side rotated right
  wire        rising = phase_low_en == {phase_high_en[0], phase_high_en[2:1]};
  wire [11:0] emf    = {2'b00, ramp_q, 5'h00} - 12'h0a0;
  wire [11:0] ph_v   = {1'b0, bus_v_level[11:1]} + (rising ? emf : -emf);
  // results hold only in the done cycle, junk otherwise
  assign phase_sample = conv_done ? ph_v : ~ph_v;
  assign bus_i_sample = conv_done ? bus_i_level : ~bus_i_level;
  assign bus_v_sample = conv_done ? bus_v_level : ~bus_v_level;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q     <= 3'h0;
      ramp_q    <= 5'h00;
      conv_done <= 1'b0;
    end else begin
      div_q     <= div_q + 3'h1;
      conv_done <= div_q == 3'h7;
      if (commutation_pulse)
        ramp_q <= 5'h00;
      else if (conv_done && ramp_q != 5'h1f)
        ramp_q <= ramp_q + 5'h01;
    end
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
`include "six_step_consts.vh"
module testbench;
  reg         clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
  reg  [3:0]  address = 4'h0, fault_in = 4'h0;
  reg  [31:0] writedata = 32'h0000_0000, q;
  reg  [11:0] v_lvl = 12'h800, i_lvl = 12'h200, d;
  reg  [15:0] m;
  wire [31:0] readdata;
  wire [11:0] ph_s, bi_s, bv_s;
  wire [2:0]  hi_en, lo_en;
  wire [15:0] duty;
  wire [1:0]  chan;
  wire        waitrequest, conv_done, cpulse, tick;
  integer     err_count = 0, checks = 0, np = 0, cyc = 0, i;
  integer     pt [0:31];

  six_step_commutation #(.TICK_CYCLES(40)) i_dut (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .conv_done(conv_done), .phase_sample(ph_s), .bus_i_sample(bi_s), .bus_v_sample(bv_s),
    .under_voltage(fault_in[0]), .over_voltage(fault_in[1]), .over_current(fault_in[2]),
    .driver_fault(fault_in[3]), .phase_high_en(hi_en), .phase_low_en(lo_en),
    .pwm_duty(duty), .back_emf_channel(chan), .commutation_pulse(cpulse),
    .speed_loop_tick(tick));
  power_stage_model i_stage (
    .clk(clk), .rst_b(rst_b), .phase_high_en(hi_en), .phase_low_en(lo_en),
    .commutation_pulse(cpulse), .bus_v_level(v_lvl), .bus_i_level(i_lvl),
    .conv_done(conv_done), .phase_sample(ph_s), .bus_i_sample(bi_s), .bus_v_sample(bv_s));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // commutation times in cycles
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (cpulse === 1'b1) begin
      if (np < 32) pt[np] = cyc;
      np = np + 1;
    end
  end

  function [31:0] rst_val(input [3:0] a);
    case (a)
      `R_INIT_PER:  rst_val = `RST_INIT_PER;
      `R_ACCEL:     rst_val = `RST_ACCEL;
      `R_OL_COUNT:  rst_val = `RST_OL_COUNT;
      `R_DECAY:     rst_val = `RST_DECAY;
      `R_DUTY_THR:  rst_val = `RST_DUTY_THR;
      `R_DUTY:      rst_val = `RST_DUTY;
      `R_ALIGN_T:   rst_val = `RST_ALIGN_T;
      `R_ALIGN_DTY: rst_val = `RST_ALIGN_DTY;
      `R_ADVANCE:   rst_val = `RST_ADVANCE;
      `R_FREEWHEEL: rst_val = `RST_FREEWHEEL;
      default:      rst_val = 32'h0000_0000;
    endcase
  endfunction

  function [15:0] next_per(input [15:0] p);
    reg [31:0] t;
    begin
      t = p * `RST_ACCEL;
      next_per = t[31:16];
    end
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task xfer(input r, input [3:0] a, input [31:0] dv);
    integer n;
    begin
      @(posedge clk);
      address   <= a;
      read      <= r;
      write     <= ~r;
      writedata <= dv;
      n = 0;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n == 50) err_count = err_count + 1;
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task wr(input [3:0] a, input [31:0] dv);
    xfer(1'b0, a, dv);
  endtask

  task rd(input [3:0] a);
    xfer(1'b1, a, 32'h0000_0000);
  endtask

  task poll(input [2:0] s);
    integer n;
    begin
      n = 0;
      rd(`R_STATUS);
      while (q[2:0] !== s && n < 3000) begin
        rd(`R_STATUS);
        n = n + 1;
      end
    end
  endtask

  task do_reset;
    begin
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
    end
  endtask

  initial begin
    #2000000;
    err_count = err_count + 1;
    end_sim;
  end

  initial begin
    q = $urandom(86081);
    do_reset;
    for (i = 0; i < 12; i = i + 1) begin
      if (i != 1) begin
        rd(i[3:0]);
        chk(q, rst_val(i[3:0]));
      end
    end
    rd(4'hf);
    chk(q, 32'h0000_0000);
    poll(`S_STOP);
    chk(q[2:0], `S_STOP);
    for (i = 2; i < 12; i = i + 1) begin
      m = $urandom;
      wr(i[3:0], {16'h0000, m});
      rd(i[3:0]);
      chk(q, i == 4 ? {24'h00_0000, m[7:0]} : {16'h0000, m});
    end
    wr(`R_STATUS, 32'hffff_ffff);
    rd(`R_STATUS);
    chk(q[2:0], `S_STOP);
    v_lvl <= 12'h700 + $urandom % 512;
    do_reset;
    m = 16'h00c0 + $urandom % 64;
    wr(`R_INIT_PER, {16'h0000, m});
    wr(`R_OL_COUNT, 32'h0000_0006);
    wr(`R_DECAY, 32'h0000_0010);
    wr(`R_ALIGN_T, 32'h0000_0002);
    wr(`R_FREEWHEEL, 32'h0000_0002);
    poll(`S_STOP);
    np = 0;
    wr(`R_CTRL, 32'h0000_0001);
    poll(`S_ALIGN);
    chk(q[2:0], `S_ALIGN);
    poll(`S_START);
    chk(q[2:0], `S_START);
    poll(`S_RUN);
    chk(q[2:0], `S_RUN);
    chk(np, 6);
    for (i = 0; i < 4; i = i + 1) begin
      m = next_per(m);
      chk(pt[i + 1] - pt[i] >= m && pt[i + 1] - pt[i] <= m + 2, 1);
    end
    i = 0;
    rd(`R_STATUS);
    while (q[9] !== 1'b1 && i < 500) begin
      rd(`R_STATUS);
      i = i + 1;
    end
    chk(q[9], 1'b1);
    wr(`R_CTRL, 32'h0000_0000);
    rd(`R_STATUS);
    chk(q[2:0] == `S_INIT || q[2:0] == `S_STOP, 1);
    for (i = 0; i < 4; i = i + 1) begin
      fault_in <= 4'h1 << i;
      repeat (4) @(posedge clk);
      rd(`R_STATUS);
      chk(q[7:0], {4'h1 << i, 4'h6});
      chk({hi_en, lo_en, duty}, 0);
      wr(`R_CTRL, 32'h0000_0002);
      rd(`R_STATUS);
      chk(q[2:0], `S_FAULT);
      fault_in <= 4'h0;
      wr(`R_CTRL, 32'h0000_0002);
      poll(`S_STOP);
      chk(q[7:0], 8'h05);
    end
    d = $urandom % 256 - 128;
    i_lvl <= 12'h200 + d;
    repeat (400) @(posedge clk);
    rd(`R_IBUS_FILT);
    chk(q, {{20{d[11]}}, d});
    rd(`R_VBUS_FILT);
    chk(q, {20'h0_0000, v_lvl});
    wr(`R_DUTY, 32'h0000_0800);
    repeat (400) @(posedge clk);
    rd(`R_IBUS_FILT);
    chk(q, 32'h0000_0000);
    end_sim;
  end
endmodule
